// file: hw/pbf_bus_glue.v
/*
  pbf_bus_glue.v: address latches, program memory select and mux, memory
  latch toward the display board with ready stall, display side decode,
  status word and forced restart for an 8-bit processor.
  assumes: state lines, cycle code and bus are sampled on clk_sys, one
  processor state per clk_sys cycle with state_en; phase clocks exist
  outside; program memory arrays live here.
*/
//Contract
//- cycles: fetch first, then read or io
//- first state strobe loads low address
//- second state strobe loads high address
//- low high bits select memory chip
//- third state drives memory onto input bus
//- each memory chip holds 256 bytes
//- memory latch holds 12 bits until consumed
//- control nibble steers data on display side
//- cursor and top line read back
//- status word shows hardware condition flags
//- io device 17 or above loads memory latch
//- pending latch drops ready on new output
//- forced reset jams restart and interrupts
//- data fetch reuses same address path
`include "pbf_map.vh"

module pbf_bus_glue #(
  parameter CHIPS  = 16,
  parameter DEPTH  = 256
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // processor side
  input  wire        state_en,
  input  wire [2:0]  proc_state,
  input  wire [7:0]  proc_out_bus,
  output reg  [7:0]  proc_in_bus,
  output wire        proc_ready,
  output wire        proc_intr,
  // program memory load port
  input  wire        pm_wr_en,
  input  wire [3:0]  pm_wr_chip,
  input  wire [7:0]  pm_wr_addr,
  input  wire [7:0]  pm_wr_data,
  // display side
  output wire [11:0] disp_word,
  output wire        disp_valid,
  input  wire        disp_take,
  output reg  [7:0]  cursor_char_q,
  output reg  [7:0]  cursor_line_q,
  output reg  [7:0]  top_line_q,
  // status and restart
  input  wire        receiver_char_complete,
  input  wire        transmitter_busy,
  input  wire        keyboard_char_complete,
  input  wire        forced_reset,
  // decoded strobes and chip select
  output wire        low_strobe_b,
  output wire        high_strobe_b,
  output reg  [15:0] pm_cs_b,
  output wire [1:0]  cycle_type
);

  reg  [7:0]  low_address_latch;
  reg  [7:0]  high_address_latch;
  reg  [11:0] mem_latch_q;
  reg         pending_q;
  reg  [7:0]  status_q;
  reg  [7:0]  pm_data_q;
  reg  [7:0]  pm_mem [0:CHIPS*DEPTH-1];

  wire [1:0]  cyc = high_address_latch[`PBF_CYC_MSB:`PBF_CYC_LSB];
  wire [4:0]  dev = high_address_latch[`PBF_DEV_MSB:`PBF_DEV_LSB];
  wire        in_t1 = (proc_state == `PBF_ST_T1) ||
                      (proc_state == `PBF_ST_T11);
  wire        in_t2 = (proc_state == `PBF_ST_T2);
  wire        in_t3 = (proc_state == `PBF_ST_T3);
  wire        io_cyc = (cyc == `PBF_CYC_IO);
  wire        disp_io = io_cyc && (dev >= `PBF_DEV_DISP_MIN);
  wire        mem_cyc = (cyc == `PBF_CYC_FETCH) ||
                        (cyc == `PBF_CYC_READ);
  wire        take_ok = disp_take && pending_q;

  // index into the flat memory; chip number above the byte offset
  function [11:0] pm_index;
    input [3:0] chip;
    input [7:0] addr;
    begin
      pm_index = {chip, addr};
    end
  endfunction

  assign cycle_type    = cyc;
  assign low_strobe_b  = ~(state_en && in_t1);
  assign high_strobe_b = ~(state_en && in_t2);
  // stall only the third state of a display output; others run free
  // a take in the same cycle frees the latch, so ready rises for the load
  assign proc_ready = ~(pending_q && !take_ok && disp_io && in_t3);
  assign proc_intr  = forced_reset;
  assign disp_word  = mem_latch_q;
  assign disp_valid = pending_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      low_address_latch  <= `PBF_RST_BYTE;
      high_address_latch <= `PBF_RST_BYTE;
    end else if (state_en) begin
      if (in_t1)
        low_address_latch <= proc_out_bus;
      if (in_t2)
        high_address_latch <= proc_out_bus;
    end
  end

  always @* begin
    pm_cs_b = 16'hFFFF;
    if (mem_cyc)
      pm_cs_b[high_address_latch[`PBF_CS_MSB:0]] = 1'b0;
  end

  // synchronous array read; load port shares the array for boot images
  always @(posedge clk_sys) begin
    if (pm_wr_en)
      pm_mem[pm_index(pm_wr_chip, pm_wr_addr)] <= pm_wr_data;
    pm_data_q <= pm_mem[pm_index(high_address_latch[`PBF_CS_MSB:0],
                                 low_address_latch)];
  end

  // memory latch with pending flag; a take and a load together keep it set
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_latch_q <= `PBF_RST_WORD;
      pending_q   <= 1'b0;
    end else begin
      if (state_en && in_t3 && disp_io && (!pending_q || take_ok)) begin
        mem_latch_q <= {dev[3:0], low_address_latch};
        pending_q   <= 1'b1;
      end else if (take_ok) begin
        pending_q <= 1'b0;
      end
    end
  end

  // display side decode of the control nibble
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cursor_char_q <= `PBF_RST_BYTE;
      cursor_line_q <= `PBF_RST_BYTE;
      top_line_q    <= `PBF_RST_BYTE;
    end else if (take_ok) begin
      case (mem_latch_q[11:`PBF_ML_CTRL_LSB])
        `PBF_DST_CHAR: cursor_char_q <= mem_latch_q[7:0];
        `PBF_DST_LINE: cursor_line_q <= mem_latch_q[7:0];
        `PBF_DST_TOP:  top_line_q    <= mem_latch_q[7:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      status_q <= `PBF_RST_BYTE;
    else begin
      status_q <= 8'h00;
      status_q[`PBF_STS_RX]  <= receiver_char_complete;
      status_q[`PBF_STS_TX]  <= transmitter_busy;
      status_q[`PBF_STS_KBD] <= keyboard_char_complete;
    end
  end

  // input bus mux; io read of devices 1..3 returns display readback
  always @* begin
    proc_in_bus = 8'h00;
    if (forced_reset)
      proc_in_bus = `PBF_RESTART_OP;
    else if (in_t3 && mem_cyc)
      proc_in_bus = pm_data_q;
    else if (in_t3 && io_cyc) begin
      case (dev)
        5'h00:   proc_in_bus = status_q;
        5'h01:   proc_in_bus = cursor_char_q;
        5'h02:   proc_in_bus = cursor_line_q;
        5'h03:   proc_in_bus = top_line_q;
        default: proc_in_bus = 8'h00;
      endcase
    end
  end

endmodule // pbf_bus_glue

// file: inc/pbf_map.vh
/*
  pbf_map.vh: state codes, cycle codes, field positions and fixed values
  for the processor bus fetch glue.
  assumes: included by bare name from the design file.
*/
`ifndef PBF_MAP_VH
`define PBF_MAP_VH

// processor state line codes
`define PBF_ST_T1       3'h2
`define PBF_ST_T11      3'h6
`define PBF_ST_T2       3'h4
`define PBF_ST_WAIT     3'h0
`define PBF_ST_T3       3'h1
`define PBF_ST_STOP     3'h3
`define PBF_ST_T4       3'h7
`define PBF_ST_T5       3'h5

// cycle type codes carried in bits 7:6 of the second-state byte
`define PBF_CYC_LSB     6
`define PBF_CYC_MSB     7
`define PBF_CYC_FETCH   2'h0
`define PBF_CYC_READ    2'h2
`define PBF_CYC_IO      2'h1
`define PBF_CYC_WRITE   2'h3

// high address byte fields
`define PBF_CS_MSB      3
`define PBF_DEV_LSB     1
`define PBF_DEV_MSB     5
`define PBF_DEV_DISP_MIN 5'h11

// memory latch word layout: control in 11:8, data in 7:0
`define PBF_ML_CTRL_LSB 8

// display side destination codes
`define PBF_DST_CHAR    4'h1
`define PBF_DST_LINE    4'h2
`define PBF_DST_TOP     4'h3

// fixed restart instruction
`define PBF_RESTART_OP  8'h0D

// status word bit positions
`define PBF_STS_RX      0
`define PBF_STS_TX      1
`define PBF_STS_KBD     2

// reset values
`define PBF_RST_BYTE    8'h00
`define PBF_RST_WORD    12'h000

`endif

// file: tb/pbf_disp_model.sv
/* pbf_disp_model.sv: display page logic taking latched words.
   assumes: shares the glue clock and async low reset. */
module pbf_disp_model #(parameter int DLY = 6) (
  input  wire logic clk_sys, rst_b, disp_valid,
  output logic      disp_take
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // slow on purpose so a second word must stall the processor
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      disp_take <= 1'b0;
    end else begin
      disp_take <= disp_valid && cnt == DLY && !disp_take;
      cnt <= (disp_valid && !disp_take) ? cnt + 1 : 0;
    end
  end
endmodule // pbf_disp_model

// file: tb/pbf_props.sv
/* pbf_props.sv: checker for the bus glue ports.
   assumes: bound to pbf_bus_glue, one clock, async low reset. */
`include "pbf_map.vh"
module pbf_props (
  input wire logic        clk_sys, rst_b, state_en, forced_reset,
  input wire logic [2:0]  proc_state,
  input wire logic [7:0]  proc_out_bus, proc_in_bus, top_line_q,
  input wire logic        proc_ready, proc_intr, disp_valid, disp_take,
  input wire logic [11:0] disp_word,
  input wire logic        low_strobe_b, high_strobe_b,
  input wire logic [15:0] pm_cs_b,
  input wire logic [1:0]  cycle_type
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    disp_valid && disp_take;
  endsequence
  a_low_strobe: assert property (state_en && proc_state == `PBF_ST_T1
    |-> !low_strobe_b) else $error("low strobe missing");
  a_high_load: assert property (!high_strobe_b
    |=> cycle_type == $past(proc_out_bus[7:6])) else $error("high latch");
  a_cs_onehot: assert property (cycle_type == `PBF_CYC_FETCH
    |-> $onehot(~pm_cs_b)) else $error("chip select not one hot");
  a_valid_hold: assert property (disp_valid && !disp_take
    |=> disp_valid && $stable(disp_word)) else $error("word lost");
  a_take_clear: assert property (s_take ##0 proc_state != `PBF_ST_T3
    |=> !disp_valid) else $error("pending not cleared");
  a_top_dest: assert property (s_take ##0 disp_word[11:8] == `PBF_DST_TOP
    |=> top_line_q == $past(disp_word[7:0])) else $error("top line");
  a_ready_stall: assert property (!proc_ready
    |-> disp_valid && proc_state == `PBF_ST_T3) else $error("bad stall");
  a_restart_jam: assert property (forced_reset
    |-> proc_intr && proc_in_bus == `PBF_RESTART_OP) else $error("restart");
endmodule // pbf_props
bind pbf_bus_glue pbf_props u_props (.*);

// file: tb/test_pbf_bus_glue.sv
/* test_pbf_bus_glue.sv: table driven bench for the bus glue.
   assumes: glue, its map header, display model and checker bind. */
`include "pbf_map.vh"
module test_pbf_bus_glue;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_b = 0, state_en = 0, pm_wr_en = 0, forced_reset = 0;
  logic receiver_char_complete = 1, transmitter_busy = 0;
  logic keyboard_char_complete = 1, disp_take, proc_ready, proc_intr;
  logic disp_valid, low_strobe_b, high_strobe_b;
  logic [2:0]  proc_state = 0;
  logic [3:0]  pm_wr_chip = 0;
  logic [7:0]  proc_out_bus = 0, pm_wr_addr = 0, pm_wr_data = 0, proc_in_bus;
  logic [7:0]  cursor_char_q, cursor_line_q, top_line_q;
  logic [11:0] disp_word;
  logic [15:0] pm_cs_b;
  logic [1:0]  cycle_type;
  int err_total = 0, total_checks = 0;
  // {low byte, high byte, input bus expected in the third state}
  logic [23:0] rows [9] = '{24'hA7053C, 24'hA8855A, 24'h116200, 24'h226400,
    24'h336600, 24'h004211, 24'h004422, 24'h004005, 24'h004633};
  always #5 clk_sys = ~clk_sys;
  pbf_bus_glue dut (.*);
  pbf_disp_model u_disp (.*);
  task chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task st(input logic [2:0] s, input logic [7:0] b);
    @(posedge clk_sys);
    state_en <= 1;
    proc_state <= s;
    proc_out_bus <= b;
  endtask
  // fetch, read and io cycles share one path; io writes may stall
  task cyc(input logic [23:0] r);
    int n;
    st(`PBF_ST_T1, r[23:16]);
    st(`PBF_ST_T2, r[15:8]);
    @(posedge clk_sys);
    state_en <= 0;
    st(`PBF_ST_T3, 8'h00);
    #1;
    for (n = 0; n < 60 && proc_ready !== 1'b1; n++) @(posedge clk_sys) #1;
    chk(proc_in_bus, r[7:0]);
    @(posedge clk_sys);
    state_en <= 0;
  endtask
  task pmw(input logic [7:0] a, d);
    @(posedge clk_sys);
    pm_wr_en <= 1;
    pm_wr_chip <= 4'h5;
    pm_wr_addr <= a;
    pm_wr_data <= d;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    #1;
    chk({disp_valid, proc_ready, low_strobe_b}, 16'h3);
    pmw(8'hA7, 8'h3C);
    pmw(8'hA8, 8'h5A);
    @(posedge clk_sys);
    pm_wr_en <= 0;
    cyc(rows[0]);
    chk(pm_cs_b, 16'hFFDF);
    foreach (rows[i]) cyc(rows[i]);
    @(posedge clk_sys);
    forced_reset <= 1;
    #1;
    chk({proc_intr, proc_in_bus}, 16'h10D);
    @(posedge clk_sys);
    forced_reset <= 0;
    repeat (20) @(posedge clk_sys);
    end_of_test;
  end
  initial begin
    #20000;
    err_total++;
    end_of_test;
  end
endmodule // test_pbf_bus_glue
